// [src/debug_serial_async_port.sv]
// debug serial port: registers, receiver and frame control
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_consts.svh"
module debug_serial_async_port (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    output logic [15:0] reg_rd_data,
    // serial pins
    input wire logic serial_in_pin,
    input wire logic clear_to_send_in_n,
    output logic serial_out_pin,
    output logic request_to_send_out_n,
    // event pulses
    output logic tx_complete_irq,
    output logic rx_complete_irq,
    output logic rx_error_irq
);
    import dsp_pkg::*;

    logic srst, tick, tx_done, wr_txd, rx_rd, rxe, ext, rx_done;
    frame_cfg_s cfg;

    // ==========================================================
    // soft reset
    logic soft_q, soft_d;

    always_comb begin
        soft_d = reg_wr_en && reg_addr == `A_SRST
            && reg_wr_data[`B_SRST];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= soft_d;
        end
    end

    // one pulse resets every other flop in the unit
    assign srst = rst | soft_q;

    // ==========================================================
    // configuration and transmit registers
    logic [7:0] mode_q, mode_d;
    logic ebs_q, ebs_d, busy_q, busy_d;
    logic [3:0] baud_q, baud_d;
    logic [8:0] txd_q, txd_d;

    assign wr_txd = reg_wr_en
        && (reg_addr == `A_TXD_EXT || reg_addr == `A_TXD_BYTE);
    assign rxe = mode_q[`B_RXE];

    always_comb begin
        mode_d = mode_q;
        ebs_d = ebs_q;
        baud_d = baud_q;
        txd_d = txd_q;
        busy_d = busy_q;
        if (reg_wr_en) begin
            case (reg_addr)
                `A_MODE_MAIN: mode_d = reg_wr_data[7:0] & `MODE_MASK;
                `A_MODE_EXT: ebs_d = reg_wr_data[`B_EBS];
                `A_BAUD: baud_d = {reg_wr_data[`B_BRCE],
                                   reg_wr_data[2:0]};
                `A_TXD_EXT: txd_d = reg_wr_data[8:0];
                `A_TXD_BYTE: txd_d = {txd_q[8], reg_wr_data[7:0]};
                default: mode_d = mode_q;
            endcase
        end
        if (tx_done) begin
            busy_d = 1'b0;
        end
        if (wr_txd) begin
            busy_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_q <= `MODE_RST;
            ebs_q <= 1'b0;
            baud_q <= 4'h0;
            txd_q <= `TX_RST_VAL;
            busy_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            ebs_q <= ebs_d;
            baud_q <= baud_d;
            txd_q <= txd_d;
            busy_q <= busy_d;
        end
    end

    // ==========================================================
    // frame format
    always_comb begin
        ext = ebs_q
            && mode_q[`B_PAR_HI:`B_PAR_LO] == `PAR_NONE;
        cfg.par = mode_q[`B_PAR_HI:`B_PAR_LO];
        cfg.two_stop = mode_q[`B_SLO];
        if (ext) begin
            cfg.nchar = `NCHAR9;
        end else if (mode_q[`B_CL]) begin
            cfg.nchar = `NCHAR8;
        end else begin
            cfg.nchar = `NCHAR7;
        end
    end

    // ==========================================================
    // serial clock and transmitter
    baud_tick u_tick (
        .sys_clk(sys_clk),
        .rst(srst),
        .en(baud_q[3]),
        .sel(baud_q[2:0]),
        .tick(tick)
    );

    // no enable gates the transmitter; writes start it directly
    tx_frame u_tx (
        .sys_clk(sys_clk),
        .rst(srst),
        .tick(tick),
        .start(wr_txd),
        .cfg(cfg),
        .data(txd_d),
        .txd(serial_out_pin),
        .done(tx_done)
    );

    // ==========================================================
    // receiver
    rx_state_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d, idx_q, idx_d, last;
    logic [8:0] sh_q, sh_d, rxb_q, rxb_d;
    logic prev_q, prev_d, perr_q, perr_d, full_q, full_d, pen;
    rx_err_s err_q, err_d;

    assign rx_rd = reg_rd_en
        && (reg_addr == `A_RXB_EXT || reg_addr == `A_RXB_BYTE);
    assign pen = (cfg.par != `PAR_NONE);
    assign last = cfg.nchar + {3'h0, pen};

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        sh_d = sh_q;
        prev_d = prev_q;
        perr_d = perr_q;
        rxb_d = rxb_q;
        err_d = err_q;
        full_d = full_q;
        rx_done = 1'b0;
        if (rx_rd) begin
            err_d = '0;
            full_d = 1'b0;
        end
        if (!rxe) begin
            // held idle; buffer and flags kept
            st_d = RX_IDLE;
            cnt_d = 4'h0;
            idx_d = 4'h0;
            prev_d = 1'b1;
        end else if (tick) begin
            prev_d = serial_in_pin;
            case (st_q)
                RX_IDLE: begin
                    if (prev_q && !serial_in_pin) begin
                        st_d = RX_START;
                        cnt_d = 4'h0;
                    end
                end
                RX_START: begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `TICK_MID) begin
                        cnt_d = 4'h0;
                        if (serial_in_pin) begin
                            st_d = RX_IDLE;
                        end else begin
                            st_d = RX_DATA;
                            idx_d = 4'h0;
                            sh_d = 9'h000;
                            perr_d = 1'b0;
                        end
                    end
                end
                RX_DATA: begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `TICK_LAST) begin
                        // midpoint sample, 16 ticks after the last
                        idx_d = idx_q + 4'h1;
                        if (idx_q < cfg.nchar) begin
                            sh_d[idx_q] = serial_in_pin;
                        end else if (idx_q < last) begin
                            perr_d = serial_in_pin
                                != par_bit(sh_q, cfg.par);
                        end else begin
                            st_d = RX_IDLE;
                            rx_done = 1'b1;
                            rxb_d = sh_q;
                            err_d.pe = perr_q;
                            err_d.fe = !serial_in_pin;
                            err_d.ove = full_q;
                            full_d = 1'b1;
                        end
                    end
                end
                default: st_d = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= RX_IDLE;
            cnt_q <= 4'h0;
            idx_q <= 4'h0;
            sh_q <= 9'h000;
            prev_q <= 1'b1;
            perr_q <= 1'b0;
            rxb_q <= 9'h000;
            err_q <= '0;
            full_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            sh_q <= sh_d;
            prev_q <= prev_d;
            perr_q <= perr_d;
            rxb_q <= rxb_d;
            err_q <= err_d;
            full_q <= full_d;
        end
    end

    // ==========================================================
    // read data and output flops
    logic [15:0] rd_d;
    logic rts_n_d, txi_d, rxc_d, rxe_i_d;

    always_comb begin
        case (reg_addr)
            `A_MODE_MAIN: rd_d = {8'h00, mode_q};
            `A_MODE_EXT: rd_d = {15'h0000, ebs_q};
            `A_RXB_EXT: rd_d = {7'h00, rxb_q};
            `A_RXB_BYTE: rd_d = {8'h00, rxb_q[7:0]};
            `A_TXD_EXT: rd_d = {7'h00, txd_q};
            `A_TXD_BYTE: rd_d = {8'h00, txd_q[7:0]};
            `A_STATUS: rd_d = {8'h00, busy_q, 4'h0, err_q};
            `A_BAUD: rd_d = {8'h00, baud_q[3], 4'h0, baud_q[2:0]};
            `A_CTS: rd_d = {15'h0000, !clear_to_send_in_n};
            default: rd_d = 16'h0000;
        endcase
        if (!reg_rd_en) begin
            rd_d = 16'h0000;
        end
        rts_n_d = !rxe;
        // only a finished frame fires; reset alone never does
        txi_d = tx_done;
        rxc_d = rx_done;
        rxe_i_d = rx_done && (err_d.pe | err_d.fe | err_d.ove);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rd_data <= 16'h0000;
            request_to_send_out_n <= 1'b1;
            tx_complete_irq <= 1'b0;
            rx_complete_irq <= 1'b0;
            rx_error_irq <= 1'b0;
        end else begin
            reg_rd_data <= rd_d;
            request_to_send_out_n <= rts_n_d;
            tx_complete_irq <= txi_d;
            rx_complete_irq <= rxc_d;
            rx_error_irq <= rxe_i_d;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_soft_reset_all: assert property (
        disable iff (rst) reg_wr_en && reg_addr == `A_SRST
        && reg_wr_data[`B_SRST]
        |=> ##1 !busy_q && st_q == RX_IDLE && !full_q && !rxe)
        else $error("soft reset did not clear the unit");

    a_rts_follows_rxe: assert property (
        1'b1 |=> request_to_send_out_n == !$past(rxe))
        else $error("request-to-send does not follow enable");

    a_rx_off_quiet: assert property (
        !rxe |=> !rx_complete_irq && !rx_error_irq
        && $stable(rxb_q))
        else $error("disabled receiver changed state");

    a_start_reject: assert property (
        rxe && st_q == RX_START && tick && cnt_q == `TICK_MID
        && serial_in_pin |=> st_q == RX_IDLE && cnt_q == 4'h0)
        else $error("false start bit not rejected");

    a_start_accept: assert property (
        rxe && st_q == RX_START && tick && cnt_q == `TICK_MID
        && !serial_in_pin |=> st_q == RX_DATA && idx_q == 4'h0)
        else $error("start bit not accepted");

    a_mid_sample: assert property (
        rxe && st_q == RX_DATA && !(tick && cnt_q == `TICK_LAST)
        |=> $stable(idx_q))
        else $error("bit sampled off its midpoint");

    a_err_with_cmp: assert property (
        rx_error_irq |-> rx_complete_irq && err_q != 3'h0)
        else $error("error event without complete event");

    a_err_or: assert property (
        rx_complete_irq |-> rx_error_irq == (|err_q))
        else $error("error event is not the OR of flags");

    a_overrun_set: assert property (
        rx_done && full_q |=> err_q.ove && full_q)
        else $error("overrun not flagged");

    a_read_clears: assert property (
        rx_rd && !rx_done |=> err_q == 3'h0 && !full_q)
        else $error("buffer read did not clear flags");

    a_busy_on_write: assert property (
        wr_txd |=> busy_q)
        else $error("transmit write did not set busy");

    a_done_clears_busy: assert property (
        tx_done && !wr_txd |=> !busy_q && tx_complete_irq)
        else $error("frame end did not clear busy and signal");

    a_no_irq_idle: assert property (
        tx_complete_irq |-> $past(busy_q))
        else $error("transmit complete without a frame");

    c_tx_frame: cover property (tx_done ##1 tx_complete_irq && !busy_q);
    c_rx_frame: cover property (rx_complete_irq && !rx_error_irq);
    c_rx_error: cover property (rx_error_irq && err_q.ove);
    c_false_start: cover property (
        st_q == RX_START ##1 st_q == RX_IDLE);

endmodule // debug_serial_async_port
`default_nettype wire

// [src/dsp_consts.svh]
// register offsets, field positions and timing figures of the debug serial port
`ifndef DSP_CONSTS_SVH
`define DSP_CONSTS_SVH

// ==========================================================
// register offsets
`define A_MODE_MAIN 8'hA0
`define A_MODE_EXT 8'hA6
`define A_RXB_EXT 8'hA8
`define A_RXB_BYTE 8'hAA
`define A_TXD_EXT 8'hAC
`define A_TXD_BYTE 8'hAE
`define A_STATUS 8'hB0
`define A_BAUD 8'hB6
`define A_SRST 8'hB8
`define A_CTS 8'hBA

// ==========================================================
// field positions and reset values
`define B_RXE 6
`define B_PAR_HI 5
`define B_PAR_LO 4
`define B_CL 3
`define B_SLO 2
`define B_EBS 0
`define B_BRCE 7
`define B_SRST 0
`define MODE_MASK 8'h7C
`define MODE_RST 8'h00
`define TX_RST_VAL 9'h1FF

// ==========================================================
// frame encodings
`define PAR_NONE 2'h0
`define PAR_ZERO 2'h1
`define PAR_ODD 2'h2
`define PAR_EVEN 2'h3
`define NCHAR7 4'h7
`define NCHAR8 4'h8
`define NCHAR9 4'h9
`define FRAME_W 13

// ==========================================================
// serial clock: 16 ticks per bit
`define TICK_MID 4'h7
`define TICK_LAST 4'hF
`define CLK_HZ 125000000
`define BAUD0 1200
`define BAUD1 2400
`define BAUD2 4800
`define BAUD3 9600
`define BAUD4 19200
`define BAUD5 38400
`define BAUD6 57600
`define BAUD7 115200
`define DIV(b) ((`CLK_HZ + 8 * (b)) / (16 * (b)))

`endif

// [src/dsp_pkg.sv]
// types shared by the debug serial port modules
package dsp_pkg;
`include "dsp_consts.svh"

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_DATA = 3'b100
    } rx_state_e;

    typedef struct packed {
        logic [3:0] nchar;
        logic [1:0] par;
        logic two_stop;
    } frame_cfg_s;

    typedef struct packed {
        logic pe;
        logic fe;
        logic ove;
    } rx_err_s;

    // parity bit for masked character data
    function automatic logic par_bit(input logic [8:0] d,
                                     input logic [1:0] par);
        case (par)
            `PAR_EVEN: par_bit = ^d;
            `PAR_ODD: par_bit = ~^d;
            default: par_bit = 1'b0;
        endcase
    endfunction

endpackage

// [src/baud_tick.sv]
// serial clock generator: one tick per sixteenth of a bit
`timescale 1ns/1ps
`default_nettype none
`include "dsp_consts.svh"
module baud_tick (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // rate control
    input wire logic en,
    input wire logic [2:0] sel,
    // tick out
    output logic tick
);
    logic [12:0] cnt_q, cnt_d, div;
    logic tick_d;

    // ==========================================================
    // divider
    always_comb begin
        case (sel)
            3'h0: div = 13'(`DIV(`BAUD0));
            3'h1: div = 13'(`DIV(`BAUD1));
            3'h2: div = 13'(`DIV(`BAUD2));
            3'h3: div = 13'(`DIV(`BAUD3));
            3'h4: div = 13'(`DIV(`BAUD4));
            3'h5: div = 13'(`DIV(`BAUD5));
            3'h6: div = 13'(`DIV(`BAUD6));
            default: div = 13'(`DIV(`BAUD7));
        endcase
        cnt_d = cnt_q + 13'h1;
        tick_d = 1'b0;
        if (!en) begin
            cnt_d = 13'h0;
        end else if (cnt_q >= div - 13'h1) begin
            cnt_d = 13'h0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q <= 13'h0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule // baud_tick
`default_nettype wire

// [src/tx_frame.sv]
// transmit shifter: builds and sends one frame per start pulse that arrives while idle
`timescale 1ns/1ps
`default_nettype none
`include "dsp_consts.svh"
module tx_frame (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // timing and request
    input wire logic tick,
    input wire logic start,
    input wire dsp_pkg::frame_cfg_s cfg,
    input wire logic [8:0] data,
    // line and completion
    output logic txd,
    output logic done
);
    import dsp_pkg::*;

    logic [`FRAME_W-1:0] sh_q, sh_d, fr;
    logic [3:0] left_q, left_d, sub_q, sub_d, len;
    logic act_q, act_d, txd_d, done_d, pe;
    logic [8:0] dm;

    // ==========================================================
    // frame build and shift
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            dm[i] = (i < int'(cfg.nchar)) ? data[i] : 1'b0;
        end
        pe = (cfg.par != `PAR_NONE);
        fr = '1;
        fr[0] = 1'b0;
        for (int i = 1; i < `FRAME_W; i++) begin
            if (i <= int'(cfg.nchar)) begin
                fr[i] = dm[i-1];
            end else if (pe && i == int'(cfg.nchar) + 1) begin
                fr[i] = par_bit(dm, cfg.par);
            end
        end
        len = cfg.nchar + 4'h1 + {3'h0, pe} + (cfg.two_stop ? 4'h2 : 4'h1);
        sh_d = sh_q;
        left_d = left_q;
        sub_d = sub_q;
        act_d = act_q;
        txd_d = txd;
        done_d = 1'b0;
        if (!act_q && start) begin
            sh_d = fr;
            left_d = len;
            sub_d = 4'h0;
            act_d = 1'b1;
            txd_d = 1'b0;
        end else if (act_q && tick) begin
            sub_d = sub_q + 4'h1;
            if (sub_q == `TICK_LAST) begin
                sh_d = {1'b1, sh_q[`FRAME_W-1:1]};
                left_d = left_q - 4'h1;
                txd_d = sh_q[1];
                if (left_q == 4'h1) begin
                    act_d = 1'b0;
                    txd_d = 1'b1;
                    done_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sh_q <= '1;
            left_q <= 4'h0;
            sub_q <= 4'h0;
            act_q <= 1'b0;
            txd <= 1'b1;
            done <= 1'b0;
        end else begin
            sh_q <= sh_d;
            left_q <= left_d;
            sub_q <= sub_d;
            act_q <= act_d;
            txd <= txd_d;
            done <= done_d;
        end
    end
endmodule // tx_frame
`default_nettype wire

// [verif/remote_term.sv]
// remote terminal model that sends and catches serial frames
`timescale 1ns/1ps
`default_nettype none
module remote_term #(
    parameter int BIT_CLKS = 1088
) (
    // clock
    input wire logic sys_clk,
    // serial lines
    input wire logic serial_out_pin,
    output logic serial_in_pin,
    output logic clear_to_send_in_n
);
    // =========
    // line idles high, terminal always ready
    initial begin
        serial_in_pin = 1'b1;
        clear_to_send_in_n = 1'b0;
    end
    // frame bits go out from bit 0 upward
    task automatic send(input logic [12:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            serial_in_pin <= f[i];
            repeat (BIT_CLKS) @(posedge sys_clk);
        end
        serial_in_pin <= 1'b1;
    endtask
    // low pulse too short to pass for a start bit
    task automatic glitch(input int c);
        serial_in_pin <= 1'b0;
        repeat (c) @(posedge sys_clk);
        serial_in_pin <= 1'b1;
        repeat (BIT_CLKS) @(posedge sys_clk);
    endtask
    // bit centres; gives up after four bit times
    task automatic grab(input int n, output logic [12:0] f);
        int t;
        f = '0;
        t = 0;
        while (serial_out_pin !== 1'b0 && t < 4 * BIT_CLKS) begin
            @(posedge sys_clk);
            t++;
        end
        repeat (BIT_CLKS / 2) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            f[i] = serial_out_pin;
            repeat (BIT_CLKS) @(posedge sys_clk);
        end
    endtask
endmodule // remote_term
`default_nettype wire

// [verif/tb_debug_serial_async_port.sv]
// self-checking bench for the debug serial port
`timescale 1ns/1ps
`default_nettype none
`include "dsp_consts.svh"
module tb_debug_serial_async_port;
    import dsp_pkg::*;
    localparam int BC = 16 * `DIV(`BAUD7);
    logic sys_clk, rst, reg_wr_en, reg_rd_en, serial_in_pin;
    logic [7:0] reg_addr;
    logic [15:0] reg_wr_data, reg_rd_data;
    logic clear_to_send_in_n, serial_out_pin, request_to_send_out_n;
    logic tx_complete_irq, rx_complete_irq, rx_error_irq;
    int n_errors = 0;
    int checks = 0;
    int cnt[3] = '{0, 0, 0};

    debug_serial_async_port DUT (.sys_clk, .rst, .reg_addr, .reg_wr_data,
        .reg_wr_en, .reg_rd_en, .reg_rd_data, .serial_in_pin,
        .clear_to_send_in_n, .serial_out_pin, .request_to_send_out_n,
        .tx_complete_irq, .rx_complete_irq, .rx_error_irq);
    remote_term #(.BIT_CLKS(BC)) term (.sys_clk, .serial_out_pin,
        .serial_in_pin, .clear_to_send_in_n);

    // =========
    // clock and event counts
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (tx_complete_irq === 1'b1) cnt[0]++;
        if (rx_complete_irq === 1'b1) cnt[1]++;
        if (rx_error_irq === 1'b1) begin
            cnt[2]++;
            chk("pair", 16'h1, 16'(rx_complete_irq));
        end
    end

    // =========
    // shared tasks
    task automatic conclude();
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rdc(input string s, input logic [7:0] a,
            input logic [15:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        #1 chk(s, e, reg_rd_data);
    endtask
    // bounded wait for a receive count
    task automatic wait_rx(input int v);
        for (int i = 0; i < 20 * BC && cnt[1] < v; i++) @(posedge sys_clk);
        if (cnt[1] < v) begin
            chk("rx count", 16'(v), 16'(cnt[1]));
            conclude();
        end
    endtask
    // one sent frame, optionally with a received one beside it
    task automatic t_tx(input logic [15:0] m, input logic [7:0] a,
            input logic [15:0] d, input logic [12:0] e, input int n,
            input logic [15:0] bs, input logic [12:0] rf, input int rn);
        logic [12:0] f;
        int b;
        b = cnt[0];
        wr(`A_MODE_MAIN, m);
        fork
            term.grab(n, f);
            term.send(rf, rn);
            begin
                wr(a, d);
                rdc("busy", `A_STATUS, bs);
            end
        join
        chk("tx frame", {3'h0, e}, {3'h0, f});
        chk("tx done", 16'(b + 1), 16'(cnt[0]));
    endtask

    // =========
    // scenarios
    task automatic t_reset();
        chk("rts_n", 16'h1, 16'(request_to_send_out_n));
        chk("tx done", 16'h0, 16'(cnt[0]));
        rdc("mode", `A_MODE_MAIN, 16'h0);
        rdc("txd", `A_TXD_EXT, 16'h1FF);
        rdc("status", `A_STATUS, 16'h0);
        rdc("cts", `A_CTS, 16'h1);
        rdc("unmapped", 8'h02, 16'h0);
    endtask
    task automatic t_duplex();
        wr(`A_BAUD, 16'h87);
        t_tx(16'h78, `A_TXD_BYTE, 16'hA5, {1'b1, ^8'hA5, 8'hA5, 1'b0},
            11, 16'h80, {1'b1, ^8'h3C, 8'h3C, 1'b0}, 11);
        wait_rx(1);
        chk("rts_n", 16'h0, 16'(request_to_send_out_n));
        rdc("status", `A_STATUS, 16'h0);
        rdc("rx byte", `A_RXB_BYTE, 16'h3C);
        t_tx(16'h60, `A_TXD_BYTE, 16'hDA, {1'b1, ~^7'h5A, 7'h5A, 1'b0},
            10, 16'h80, {1'b1, 1'b0, 7'h3C, 1'b0}, 10);
        wait_rx(2);
        chk("err irq", 16'h1, 16'(cnt[2]));
        rdc("parity", `A_STATUS, 16'h4);
    endtask
    task automatic t_ext();
        wr(`A_MODE_EXT, 16'h1);
        term.glitch(3 * BC / 16);
        t_tx(16'h58, `A_TXD_EXT, 16'h155, {1'b1, 1'b0, 8'h55, 1'b0},
            11, 16'h84, {1'b0, 1'b0, 8'h81, 1'b0}, 11);
        wait_rx(3);
        chk("err irq", 16'h2, 16'(cnt[2]));
        rdc("fe ove", `A_STATUS, 16'h3);
        rdc("overrun", `A_RXB_EXT, 16'h81);
        rdc("cleared", `A_STATUS, 16'h0);
        t_tx(16'h0C, `A_TXD_EXT, 16'h155, {2'b11, 9'h155, 1'b0},
            12, 16'h80, 13'h0, 0);
        chk("rts_n", 16'h1, 16'(request_to_send_out_n));
    endtask
    task automatic t_off();
        wr(`A_MODE_MAIN, 16'h78);
        fork
            term.send({1'b1, ^8'h55, 8'h55, 1'b0}, 11);
            begin
                repeat (4 * BC) @(posedge sys_clk);
                wr(`A_MODE_MAIN, 16'h38);
            end
        join
        repeat (BC) @(posedge sys_clk);
        chk("rx count", 16'h3, 16'(cnt[1]));
        chk("err irq", 16'h2, 16'(cnt[2]));
        rdc("kept", `A_RXB_EXT, 16'h81);
    endtask
    task automatic t_srst();
        int b;
        b = cnt[0];
        wr(`A_TXD_BYTE, 16'h0);
        repeat (3 * BC) @(posedge sys_clk);
        wr(`A_SRST, 16'h1);
        repeat (10 * BC) @(posedge sys_clk);
        chk("tx done", 16'(b), 16'(cnt[0]));
        chk("line", 16'h1, 16'(serial_out_pin));
        rdc("mode", `A_MODE_MAIN, 16'h0);
        rdc("txd", `A_TXD_EXT, 16'h1FF);
        rdc("srst", `A_SRST, 16'h0);
    endtask

    initial begin
        rst = 1'b1;
        reg_addr = 8'h0;
        reg_wr_data = 16'h0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_duplex();
        t_ext();
        t_off();
        t_srst();
        conclude();
    end
endmodule // tb_debug_serial_async_port
`default_nettype wire
